// file: bench/motor_side.sv
// Far-side model: battery, supply and homing.
// Assumes pwr_cyc and home_req are one-cycle pulses.
`timescale 1ns/1ps
module motor_side (
  input wire sys_clk,
  input wire pwr_cyc,
  input wire home_req,
  output wire battery_connector,
  output logic power_up = 1'b1,
  output logic home_done = 1'b0
);
  int n = 0;
  assign battery_connector = 1'b1; // Battery stays fitted
  always @(posedge sys_clk) begin
    // Off long enough for the two-flop sync to see it
    n <= pwr_cyc ? 6 : (n > 0 ? n - 1 : 0);
    power_up <= !(pwr_cyc || n > 1);
    home_done <= home_req; // Homing reported done one cycle after the request
  end
endmodule // motor_side

// file: bench/mtab_chk.sv
// Checker on the block's top ports.
// Assumes one clock and default widths.
`timescale 1ns/1ps
module mtab_chk (
  input wire sys_clk,
  input wire arst_n,
  input wire acc_type,
  input wire smooth_en,
  input wire linked_run,
  input wire ramping,
  input wire ctrl_mode,
  input wire backup_en,
  input wire power_up,
  input wire alarm_clear,
  input wire [8:0] err_gain1,
  input wire [8:0] err_gain2,
  input wire [15:0] common_acc,
  input wire [15:0] entry_acc,
  input wire [15:0] acc_out,
  input wire smooth_out,
  input wire [8:0] err_gain_out,
  input wire cur_mode_out,
  input wire [5:0] pos_gain_out,
  input wire cable_lost,
  input wire battery_connector,
  input wire retain_out,
  input wire abs_alarm,
  input wire abs_move_ok
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_acc_src: assert property (
    $past(arst_n) && !$past(linked_run) |-> acc_out == ($past(acc_type) ? $past(entry_acc) : $past(common_acc))
  ) else $error("acc source");
  a_smooth_follow: assert property (
    $past(arst_n) |-> smooth_out == $past(smooth_en)) else $error("smooth");
  a_mode_follow: assert property (
    $past(arst_n) |-> cur_mode_out == $past(ctrl_mode)) else $error("mode");
  a_loop_gate: assert property (
    !cur_mode_out |-> pos_gain_out == 6'h00) else $error("loop gain");
  a_err_gain: assert property (
    $past(arst_n) && $past(err_gain1) <= 9'h1F4 && $past(err_gain2) <= 9'h1F4
    |-> err_gain_out == ($past(ramping) ? $past(err_gain2) : $past(err_gain1))) else $error("err gain");
  a_alarm_set: assert property (
    $rose(power_up) && backup_en && !retain_out |-> ##[2:4] abs_alarm) else $error("alarm set");
  a_keep_armed: assert property (
    $rose(power_up) && retain_out |=> !abs_alarm [*4]) else $error("alarm on referenced power-up");
  a_cable_alarm: assert property (
    $rose(cable_lost) && backup_en && battery_connector |-> ##[2:4] abs_alarm) else $error("cable alarm");
  a_alarm_hold: assert property (
    abs_alarm && !alarm_clear |=> abs_alarm) else $error("alarm hold");
  a_move_block: assert property (
    abs_alarm && $past(abs_alarm) |-> !abs_move_ok) else $error("move ok");
endmodule // mtab_chk
bind motion_tuning_and_abs_backup mtab_chk chk_u (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .acc_type(acc_type),
  .smooth_en(smooth_en),
  .linked_run(linked_run),
  .ramping(ramping),
  .ctrl_mode(ctrl_mode),
  .backup_en(backup_en),
  .power_up(power_up),
  .alarm_clear(alarm_clear),
  .err_gain1(err_gain1),
  .err_gain2(err_gain2),
  .common_acc(common_acc),
  .entry_acc(entry_acc),
  .acc_out(acc_out),
  .smooth_out(smooth_out),
  .err_gain_out(err_gain_out),
  .cur_mode_out(cur_mode_out),
  .pos_gain_out(pos_gain_out),
  .cable_lost(cable_lost),
  .battery_connector(battery_connector),
  .retain_out(retain_out),
  .abs_alarm(abs_alarm),
  .abs_move_ok(abs_move_ok)
);

// file: bench/test_motion_tuning_and_abs_backup.sv
// Testbench for the motion tuning and backup block.
// Assumes the far-side model and bound checker.
`timescale 1ns/1ps
module test_motion_tuning_and_abs_backup;
  logic sys_clk = 0, arst_n = 0, acc_type = 1, smooth_en = 1, filt_sel = 0, ctrl_mode = 0;
  logic op_start = 0, linked_run = 0, ramping = 0, backup_en = 0, alarm_clear = 0;
  logic cable_lost = 0, abs_move_req = 0, pwr_cyc = 0, home_req = 0;
  logic [7:0] spd_filt_ms = 8'h01, mavg_ms = 8'h01, spd_gain = 8'h20;
  logic [8:0] err_gain1 = 9'h011, err_gain2 = 9'h022;
  logic [5:0] pos_gain = 6'h14;
  logic [10:0] integ_tc = 11'h100;
  logic [15:0] common_acc = 16'h1111, common_dec = 16'h2222, entry_acc = 16'h3333, entry_dec = 16'h4444;
  logic [15:0] cmd_in = 16'h0000;
  wire [15:0] acc_out, dec_out, cmd_out;
  wire [8:0] err_gain_out;
  wire [5:0] pos_gain_out;
  wire [7:0] spd_gain_out;
  wire [10:0] integ_out;
  wire smooth_out, cur_mode_out, retain_out, abs_alarm, abs_move_ok, battery_connector, power_up, home_done;
  int failures = 0, samples_checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  // Short tick keeps the filter waits small
  motion_tuning_and_abs_backup #(.MS_DIV(10)) dut_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .acc_type(acc_type),
    .smooth_en(smooth_en),
    .filt_sel(filt_sel),
    .spd_filt_ms(spd_filt_ms),
    .mavg_ms(mavg_ms),
    .err_gain1(err_gain1),
    .err_gain2(err_gain2),
    .ctrl_mode(ctrl_mode),
    .pos_gain(pos_gain),
    .spd_gain(spd_gain),
    .integ_tc(integ_tc),
    .common_acc(common_acc),
    .common_dec(common_dec),
    .entry_acc(entry_acc),
    .entry_dec(entry_dec),
    .op_start(op_start),
    .linked_run(linked_run),
    .ramping(ramping),
    .cmd_in(cmd_in),
    .backup_en(backup_en),
    .battery_connector(battery_connector),
    .power_up(power_up),
    .alarm_clear(alarm_clear),
    .home_done(home_done),
    .cable_lost(cable_lost),
    .abs_move_req(abs_move_req),
    .acc_out(acc_out),
    .dec_out(dec_out),
    .smooth_out(smooth_out),
    .cmd_out(cmd_out),
    .err_gain_out(err_gain_out),
    .cur_mode_out(cur_mode_out),
    .pos_gain_out(pos_gain_out),
    .spd_gain_out(spd_gain_out),
    .integ_out(integ_out),
    .retain_out(retain_out),
    .abs_alarm(abs_alarm),
    .abs_move_ok(abs_move_ok)
  );
  motor_side far_u (
    .sys_clk(sys_clk),
    .pwr_cyc(pwr_cyc),
    .home_req(home_req),
    .battery_connector(battery_connector),
    .power_up(power_up),
    .home_done(home_done)
  );
  task w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task finish_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    finish_test;
  end
  initial begin
    w(8);
    chk("smooth_out", 1, smooth_out);
    chk("cur_mode_out", 0, cur_mode_out);
    @(posedge sys_clk) arst_n <= 1;
    acc_type <= 0;
    w(2);
    chk("acc_out", 16'h1111, acc_out);
    chk("dec_out", 16'h2222, dec_out);
    @(posedge sys_clk) acc_type <= 1;
    op_start <= 1;
    linked_run <= 1;
    @(posedge sys_clk) op_start <= 0;
    entry_acc <= 16'h5555;
    w(3);
    chk("acc_out", 16'h3333, acc_out);
    @(posedge sys_clk) linked_run <= 0;
    smooth_en <= 0;
    spd_filt_ms <= 0;
    cmd_in <= 16'h0ABC;
    w(40);
    chk("acc_out", 16'h5555, acc_out);
    chk("smooth_out", 0, smooth_out);
    chk("cmd_out", 16'h0ABC, cmd_out);
    @(posedge sys_clk) filt_sel <= 1;
    cmd_in <= 16'h0123;
    ramping <= 1;
    w(40);
    chk("cmd_out", 16'h0123, cmd_out);
    chk("err_gain_out", 9'h022, err_gain_out);
    chk("pos_gain_out", 0, pos_gain_out);
    chk("spd_gain_out", 0, spd_gain_out);
    chk("integ_out", 0, integ_out);
    @(posedge sys_clk) ctrl_mode <= 1;
    ramping <= 0;
    w(2);
    chk("err_gain_out", 9'h011, err_gain_out);
    chk("integ_out", 11'h100, integ_out);
    chk("spd_gain_out", 8'h20, spd_gain_out);
    @(posedge sys_clk) pos_gain <= 6'h3F;
    w(2);
    chk("pos_gain_out", 6'h32, pos_gain_out);
    @(posedge sys_clk) filt_sel <= 0;
    spd_filt_ms <= 8'h01;
    cmd_in <= 16'h0456;
    w(40);
    chk("cmd_out", 16'h0456, cmd_out);
    @(posedge sys_clk) backup_en <= 1;
    abs_move_req <= 1;
    pwr_cyc <= 1;
    @(posedge sys_clk) pwr_cyc <= 0;
    w(16);
    chk("abs_alarm", 1, abs_alarm);
    chk("abs_move_ok", 0, abs_move_ok);
    @(posedge sys_clk) alarm_clear <= 1;
    @(posedge sys_clk) alarm_clear <= 0;
    w(2);
    chk("abs_alarm", 0, abs_alarm);
    @(posedge sys_clk) home_req <= 1;
    @(posedge sys_clk) home_req <= 0;
    w(5);
    chk("retain_out", 1, retain_out);
    chk("abs_move_ok", 1, abs_move_ok);
    @(posedge sys_clk) pwr_cyc <= 1;
    @(posedge sys_clk) pwr_cyc <= 0;
    w(16);
    chk("abs_alarm", 0, abs_alarm);
    chk("retain_out", 1, retain_out);
    @(posedge sys_clk) cable_lost <= 1;
    w(5);
    chk("abs_alarm", 1, abs_alarm);
    chk("retain_out", 0, retain_out);
    chk("abs_move_ok", 0, abs_move_ok);
    finish_test;
  end
endmodule // test_motion_tuning_and_abs_backup

// file: hw/motion_tuning_and_abs_backup.v
// Motion tuning selection, command filtering and absolute-position backup alarm.
// Assumes settings are static or from sys_clk logic; battery and power-up pins are asynchronous.
`timescale 1ns/1ps
`include "motion_tuning_defs.vh"
module motion_tuning_and_abs_backup #(
  parameter integer MS_DIV = `CYC_PER_MS,
  parameter integer CW = 16
) (
  input wire sys_clk,
  input wire arst_n,
  input wire acc_type,
  input wire smooth_en,
  input wire filt_sel,
  input wire [7:0] spd_filt_ms,
  input wire [7:0] mavg_ms,
  input wire [8:0] err_gain1,
  input wire [8:0] err_gain2,
  input wire ctrl_mode,
  input wire [5:0] pos_gain,
  input wire [7:0] spd_gain,
  input wire [10:0] integ_tc,
  input wire [CW-1:0] common_acc,
  input wire [CW-1:0] common_dec,
  input wire [CW-1:0] entry_acc,
  input wire [CW-1:0] entry_dec,
  input wire op_start,
  input wire linked_run,
  input wire ramping,
  input wire [CW-1:0] cmd_in,
  input wire backup_en,
  input wire battery_connector,
  input wire power_up,
  input wire alarm_clear,
  input wire home_done,
  input wire cable_lost,
  input wire abs_move_req,
  output reg [CW-1:0] acc_out,
  output reg [CW-1:0] dec_out,
  output reg smooth_out,
  output reg [CW-1:0] cmd_out,
  output reg [8:0] err_gain_out,
  output reg cur_mode_out,
  output reg [5:0] pos_gain_out,
  output reg [7:0] spd_gain_out,
  output reg [10:0] integ_out,
  output reg retain_out,
  output reg abs_alarm,
  output reg abs_move_ok
);
  function [7:0] clip8;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      clip8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [8:0] clip9;
    input [8:0] v;
    input [8:0] hi;
    begin
      clip9 = (v > hi) ? hi : v;
    end
  endfunction

  wire tick;
  ms_tick #(.DIV(MS_DIV)) u_tick (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Asynchronous pins pass two flops first
  reg [1:0] bat_s_q, pwr_s_q, cab_s_q;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bat_s_q <= 2'h0;
      pwr_s_q <= 2'h0;
      cab_s_q <= 2'h0;
    end else begin
      bat_s_q <= {bat_s_q[0], battery_connector};
      pwr_s_q <= {pwr_s_q[0], power_up};
      cab_s_q <= {cab_s_q[0], cable_lost};
    end
  end
  reg pwr_d1_q;
  wire pwr_rise = pwr_s_q[1] & ~pwr_d1_q;

  // Accel/decel source, frozen during a linked sequence
  reg linked_q;
  reg [CW-1:0] hold_acc_q, hold_dec_q;
  wire [CW-1:0] sel_acc = acc_type ? entry_acc : common_acc;
  wire [CW-1:0] sel_dec = acc_type ? entry_dec : common_dec;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      linked_q <= 1'b0;
      hold_acc_q <= {CW{1'b0}};
      hold_dec_q <= {CW{1'b0}};
      acc_out <= {CW{1'b0}};
      dec_out <= {CW{1'b0}};
    end else begin
      if (op_start && !linked_q) begin
        hold_acc_q <= sel_acc;
        hold_dec_q <= sel_dec;
      end
      linked_q <= linked_run & (linked_q | op_start);
      // Later entries of a linked run reuse the first entry's ramps
      acc_out <= (linked_q && linked_run) ? hold_acc_q : sel_acc;
      dec_out <= (linked_q && linked_run) ? hold_dec_q : sel_dec;
    end
  end

  // Command shaping: first-order speed filter or moving average, ms steps
  reg [CW+7:0] lp_q;
  reg [CW-1:0] win_q [0:255];
  reg [7:0] wptr_q;
  reg [CW+7:0] sum_q;
  reg [7:0] mlen_q;
  reg [7:0] fill_q;
  wire [7:0] tc = clip8(spd_filt_ms, 8'h00, `SPD_FILT_MAX);
  wire [7:0] mlen = clip8(mavg_ms, `MAVG_MIN, `MAVG_MAX);
  // Divisor never zero; the bypass path ignores the step anyway
  wire [7:0] tc_div = (tc == 8'h00) ? 8'h01 : tc;
  wire [CW+7:0] lp_in = {cmd_in, 8'h00};
  wire [CW+7:0] lp_step = (lp_in >= lp_q) ? (lp_in - lp_q) / tc_div : (lp_q - lp_in) / tc_div;
  wire [CW+7:0] avg = sum_q / mlen_q;
  wire [7:0] oldest_ptr = wptr_q - mlen;
  wire [CW-1:0] oldest = win_q[oldest_ptr];
  always @(posedge sys_clk) begin
    if (tick) begin
      win_q[wptr_q] <= cmd_in;
    end
  end
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_q <= {(CW+8){1'b0}};
      wptr_q <= 8'h00;
      sum_q <= {(CW+8){1'b0}};
      mlen_q <= `MAVG_RST;
      fill_q <= 8'h00;
      cmd_out <= {CW{1'b0}};
    end else begin
      if (tick) begin
        if (tc == 8'h00) begin
          lp_q <= lp_in;
        end else if (lp_in >= lp_q) begin
          lp_q <= lp_q + lp_step;
        end else begin
          lp_q <= lp_q - lp_step;
        end
        wptr_q <= wptr_q + 8'h01;
        // A change of window length restarts the average to avoid stale samples
        // The window is not reset, so nothing is subtracted until it has filled
        if (mlen != mlen_q) begin
          mlen_q <= mlen;
          sum_q <= {8'h00, cmd_in};
          fill_q <= 8'h01;
        end else if (fill_q < mlen_q) begin
          sum_q <= sum_q + {8'h00, cmd_in};
          fill_q <= fill_q + 8'h01;
        end else begin
          sum_q <= sum_q + {8'h00, cmd_in} - {8'h00, oldest};
        end
      end
      if (filt_sel) begin
        cmd_out <= avg[CW-1:0];
      end else if (tc == 8'h00) begin
        cmd_out <= cmd_in;
      end else begin
        cmd_out <= lp_q[CW+7:8];
      end
    end
  end

  // Gains, mode and backup alarm
  reg [8:0] g1, g2;
  always @* begin
    g1 = clip9(err_gain1, `ERR_GAIN_MAX);
    g2 = clip9(err_gain2, `ERR_GAIN_MAX);
  end
  reg armed_q;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_gain_out <= 9'h000;
      cur_mode_out <= `CTRL_MODE_RST;
      pos_gain_out <= 6'h00;
      spd_gain_out <= 8'h00;
      integ_out <= 11'h000;
      smooth_out <= `SMOOTH_RST;
      pwr_d1_q <= 1'b0;
      armed_q <= 1'b0;
      retain_out <= 1'b0;
      abs_alarm <= 1'b0;
      abs_move_ok <= 1'b0;
    end else begin
      smooth_out <= smooth_en;
      err_gain_out <= ramping ? g2 : g1;
      cur_mode_out <= ctrl_mode;
      // Loop gains are zeroed in normal mode so they cannot steer the loop
      pos_gain_out <= ctrl_mode ? ((pos_gain < `POS_GAIN_MIN) ? `POS_GAIN_MIN :
                      (pos_gain > `POS_GAIN_MAX) ? `POS_GAIN_MAX : pos_gain) : 6'h00;
      spd_gain_out <= ctrl_mode ? clip8(spd_gain, `SPD_GAIN_MIN, `SPD_GAIN_MAX) : 8'h00;
      integ_out <= ctrl_mode ? ((integ_tc < `INTEG_MIN) ? `INTEG_MIN :
                   (integ_tc > `INTEG_MAX) ? `INTEG_MAX : integ_tc) : 11'h000;
      pwr_d1_q <= pwr_s_q[1];
      // A referenced position survives a power cycle while the battery stays fitted
      if (cab_s_q[1] || !bat_s_q[1] || !backup_en) begin
        armed_q <= 1'b0;
      end else if (home_done && !abs_alarm) begin
        armed_q <= 1'b1;
      end
      retain_out <= backup_en & bat_s_q[1] & armed_q & ~abs_alarm;
      // Set wins over clear; power-up alarms only when no reference is armed
      if (backup_en && ((pwr_rise && !armed_q) || (cab_s_q[1] && bat_s_q[1]))) begin
        abs_alarm <= 1'b1;
      end else if (alarm_clear) begin
        abs_alarm <= 1'b0;
      end
      abs_move_ok <= abs_move_req & ~abs_alarm & (~backup_en | armed_q);
    end
  end
endmodule // motion_tuning_and_abs_backup

// file: hw/motion_tuning_defs.vh
// Constants for the motion tuning and absolute-position backup block.
// Assumes inclusion by bare name from design files under hw/.
// Notes on behaviour
// - Accel type 0 common, 1 per entry
// - Linked runs keep first entry's accel/decel
// - Smooth drive enable, default enabled
// - Filter select 0 speed, 1 moving average
// - Speed filter 0 to 200 ms; zero bypasses
// - Moving average time 1 to 200 ms
// - Gain 1 constant speed, gain 2 ramps
// - Control mode 0 normal, 1 current control
// - Loop gains act only in current mode
// - Backup enabled with battery retains position
// - Alarm after backup enable and power cycle
// - Keep power until homing or preset done
`ifndef MOTION_TUNING_DEFS_VH
`define MOTION_TUNING_DEFS_VH
`define CLK_HZ 200000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define ACC_TYPE_RST 1'h1
`define SMOOTH_RST 1'h1
`define FILT_SEL_RST 1'h0
`define SPD_FILT_MAX 8'hC8
`define SPD_FILT_RST 8'h01
`define MAVG_MIN 8'h01
`define MAVG_MAX 8'hC8
`define MAVG_RST 8'h01
`define ERR_GAIN_MAX 9'h1F4
`define CTRL_MODE_RST 1'h0
`define POS_GAIN_MIN 6'h01
`define POS_GAIN_MAX 6'h32
`define POS_GAIN_RST 6'h0A
`define SPD_GAIN_MIN 8'h0A
`define SPD_GAIN_MAX 8'hC8
`define SPD_GAIN_RST 8'hB4
`define INTEG_MIN 11'h064
`define INTEG_MAX 11'h7D0
`define INTEG_RST 11'h3E8
`define BACKUP_RST 1'h0
`endif

// file: hw/ms_tick.v
// Millisecond tick divider.
// Assumes a free-running sys_clk at the rate given in the constants header.
`timescale 1ns/1ps
`include "motion_tuning_defs.vh"
module ms_tick #(
  parameter integer DIV = `CYC_PER_MS
) (
  input wire sys_clk,
  input wire arst_n,
  output reg tick
);
  reg [31:0] cnt_q;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q >= DIV - 1) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // ms_tick
